// *** rtl/dclo_defines.svh ***
`ifndef DCLO_DEFINES_SVH
`define DCLO_DEFINES_SVH

`define DCLO_CLK_MHZ 25
`define DCLO_SLOT_US 20
`define DCLO_SLOT_CYC (`DCLO_SLOT_US * `DCLO_CLK_MHZ)
`define DCLO_POS_MIN_US 100
`define DCLO_POS_MIN_CYC (`DCLO_POS_MIN_US * `DCLO_CLK_MHZ)
`define DCLO_POWER_ON_US 200
`define DCLO_POWER_ON_CYC (`DCLO_POWER_ON_US * `DCLO_CLK_MHZ)
`define DCLO_DIR_DLY_NS 1000
`define DCLO_DIR_DLY_CYC ((`DCLO_DIR_DLY_NS * `DCLO_CLK_MHZ) / 1000)
`define DCLO_SYNC_W 6

`define DCLO_CTRL_OFS 12'h000
`define DCLO_STATUS_OFS 12'h004
`define DCLO_CTRL_RESET 2'h0
`define DCLO_CTRL_RESTART_BIT 0
`define DCLO_CTRL_DIRINV_BIT 1
`define DCLO_STAT_LATCH_LSB 0
`define DCLO_STAT_POS_BIT 2
`define DCLO_STAT_RUN_BIT 3
`define DCLO_STAT_DIRVALID_BIT 4
`define DCLO_STAT_SPEED_BIT 5
`define DCLO_STAT_PINS_LSB 6

`endif

// *** rtl/dclo_pkg.sv ***
package dclo_pkg;

	typedef enum logic [1:0] {
		PH_POWER,
		PH_POS,
		PH_RUN
	} dclo_phase_t;

	typedef struct packed {
		logic psel;
		logic penable;
		logic pwrite;
		logic [11:0] paddr;
		logic [31:0] pwdata;
		logic [3:0] pstrb;
	} dclo_apb_req_t;

	typedef struct packed {
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} dclo_apb_rsp_t;

	typedef struct packed {
		logic [1:0] beyondOp;
		logic [1:0] beyondRp;
	} dclo_field_t;

	typedef struct packed {
		logic [5:0] s1;
		logic [5:0] s2;
		logic [5:0] s3;
		logic [5:0] q;
	} dclo_sync_t;

	typedef struct packed {
		logic [15:0] cnt;
		logic sel;
	} dclo_slot_t;

	typedef struct packed {
		dclo_phase_t phase;
		logic [15:0] porCnt;
		logic [1:0][11:0] lowCnt;
		logic [1:0] setLow;
		logic [1:0] latch;
		logic lastCh;
		logic dirValid;
		logic dirCw;
		logic speed;
		logic spdPend;
		logic [7:0] dlyCnt;
		logic dirInv;
		logic [1:0] pinLvl;
		logic [31:0] prdata;
		logic pslverr;
	} dclo_core_t;

endpackage : dclo_pkg

// *** rtl/dclo_sync.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dclo_defines.svh"

module dclo_sync (
	input wire logic clk,
	input wire logic rstn,
	input wire logic [`DCLO_SYNC_W-1:0] async,
	output logic [`DCLO_SYNC_W-1:0] synced
);
	dclo_pkg::dclo_sync_t st_q;
	dclo_pkg::dclo_sync_t st_d;
	logic [`DCLO_SYNC_W-1:0] agree;

	// A bit is taken only once the second and third stages agree.
	always_comb begin
		st_d = st_q;
		agree = ~(st_q.s2 ^ st_q.s3);
		st_d.s1 = async;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		st_d.q = (agree & st_q.s3) | (~agree & st_q.q);
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign synced = st_q.q;

endmodule : dclo_sync
`default_nettype wire

// *** rtl/dclo_slot_timer.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dclo_defines.svh"

module dclo_slot_timer #(
	parameter int SLOT_CYC = `DCLO_SLOT_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	output logic sel,
	output logic slotEnd
);
	dclo_pkg::dclo_slot_t st_q;
	dclo_pkg::dclo_slot_t st_d;
	logic endNow;

	always_comb begin
		st_d = st_q;
		endNow = (st_q.cnt == 16'(SLOT_CYC - 1));
		if (endNow) begin
			st_d.cnt = '0;
			st_d.sel = ~st_q.sel;
		end else begin
			st_d.cnt = st_q.cnt + 16'h0001;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign sel = st_q.sel;
	assign slotEnd = endNow;

	property p_slot_alternate;
		@(posedge clk) disable iff (!rstn)
		endNow |=> (st_q.sel != $past(st_q.sel)) && (st_q.cnt == 16'h0000);
	endproperty
	a_slot_alternate: assert property (p_slot_alternate) else $error("Slot select did not toggle at slot end.");

endmodule : dclo_slot_timer
`default_nettype wire

// *** rtl/dclo_top.sv ***
`timescale 1ns/100ps
`default_nettype none
`include "dclo_defines.svh"

module dclo_top #(
	parameter bit SPEED_DIR_MODE = 1'b1,
	parameter bit DIR_CW_LEVEL = 1'b1,
	parameter bit POS_FEATURE = 1'b1,
	parameter int POWER_ON_CYC = `DCLO_POWER_ON_CYC,
	parameter int SLOT_CYC = `DCLO_SLOT_CYC,
	parameter int POS_MIN_CYC = `DCLO_POS_MIN_CYC,
	parameter int DIR_DLY_CYC = `DCLO_DIR_DLY_CYC
) (
	input wire logic clk,
	input wire logic rstn,
	input wire dclo_pkg::dclo_apb_req_t apbReq,
	output dclo_pkg::dclo_apb_rsp_t apbRsp,
	input wire dclo_pkg::dclo_field_t field,
	input wire logic [1:0] pinIn,
	output logic [1:0] pinOut,
	output logic [1:0] pinOeN
);
	dclo_pkg::dclo_core_t core_q;
	dclo_pkg::dclo_core_t core_d;
	dclo_pkg::dclo_field_t fieldS;
	logic [1:0] pinS;
	logic sel;
	logic slotEnd;
	logic active;
	logic sampled;
	logic trans;
	logic porDone;
	logic restart;
	logic setup;
	logic wrAcc;
	logic [1:0] initLatch;
	logic [1:0] band;

	// ****************************************
	// Input synchronisation and slot timing
	// ****************************************

	dclo_sync u_sync (
		.clk(clk),
		.rstn(rstn),
		.async({pinIn, field}),
		.synced({pinS, fieldS})
	);

	dclo_slot_timer #(
		.SLOT_CYC(SLOT_CYC)
	) u_slot (
		.clk(clk),
		.rstn(rstn),
		.sel(sel),
		.slotEnd(slotEnd)
	);

	// ****************************************
	// Helper functions
	// ****************************************

	// Latch rule for one channel: low beyond operate, high beyond release.
	function automatic logic next_latch(input logic beyondOp, input logic beyondRp, input logic cur);
		logic res;
		res = cur;
		if (beyondOp) begin
			res = 1'b0;
		end else if (beyondRp) begin
			res = 1'b1;
		end
		return res;
	endfunction : next_latch

	// Quadrature decode of one edge; true means clockwise.
	function automatic logic edge_cw(input logic ch, input logic newVal, input logic other);
		logic res;
		if (ch == 1'b0) begin
			res = (newVal != other);
		end else begin
			res = (newVal == other);
		end
		return res;
	endfunction : edge_cw

	// ****************************************
	// Wake-up state selection
	// ****************************************

	always_comb begin
		band = ~(fieldS.beyondOp | fieldS.beyondRp);
		for (int i = 0; i < 2; i++) begin
			initLatch[i] = next_latch(fieldS.beyondOp[i], fieldS.beyondRp[i], 1'b1);
			if (POS_FEATURE && !SPEED_DIR_MODE && band[i] && core_q.setLow[i]) begin
				initLatch[i] = 1'b0;
			end
		end
		// Only the speed pin carries a setting; the band channel is chosen so A xor B is low.
		if (POS_FEATURE && SPEED_DIR_MODE && core_q.setLow[0]) begin
			if (band[1]) begin
				initLatch[1] = initLatch[0];
			end else if (band[0]) begin
				initLatch[0] = initLatch[1];
			end
		end
	end

	// Direction level for a given decoded sense, including the software inversion.
	function automatic logic dirLevelNext(input logic cw);
		logic res;
		res = (cw ? DIR_CW_LEVEL : ~DIR_CW_LEVEL) ^ core_q.dirInv;
		return res;
	endfunction : dirLevelNext

	// ****************************************
	// Core state update
	// ****************************************

	assign setup = apbReq.psel && !apbReq.penable;
	assign wrAcc = apbReq.psel && apbReq.penable && apbReq.pwrite;
	assign restart = wrAcc && (apbReq.paddr == `DCLO_CTRL_OFS) && apbReq.pstrb[0]
		&& apbReq.pwdata[`DCLO_CTRL_RESTART_BIT];
	assign active = (core_q.phase != dclo_pkg::PH_POWER);
	assign porDone = (core_q.phase == dclo_pkg::PH_POWER) && (core_q.porCnt == 16'(POWER_ON_CYC - 1));
	assign sampled = next_latch(fieldS.beyondOp[sel], fieldS.beyondRp[sel], core_q.latch[sel]);
	assign trans = active && slotEnd && (sampled != core_q.latch[sel]);

	always_comb begin
		core_d = core_q;
		case (core_q.phase)
			dclo_pkg::PH_POWER: begin
				core_d.porCnt = core_q.porCnt + 16'h0001;
				for (int i = 0; i < 2; i++) begin
					if (pinS[i]) begin
						core_d.lowCnt[i] = '0;
					end else if (core_q.lowCnt[i] != 12'(POS_MIN_CYC)) begin
						core_d.lowCnt[i] = core_q.lowCnt[i] + 12'h001;
					end
					if (core_q.lowCnt[i] == 12'(POS_MIN_CYC - 1)) begin
						core_d.setLow[i] = 1'b1;
					end
				end
				if (porDone) begin
					core_d.latch = initLatch;
					core_d.speed = initLatch[0] ^ initLatch[1];
					core_d.dirValid = 1'b0;
					core_d.phase = POS_FEATURE ? dclo_pkg::PH_POS : dclo_pkg::PH_RUN;
				end
			end
			dclo_pkg::PH_POS: begin
				if (trans) begin
					core_d.phase = dclo_pkg::PH_RUN;
				end
			end
			dclo_pkg::PH_RUN: begin
				core_d.phase = dclo_pkg::PH_RUN;
			end
			default: begin
				core_d.phase = dclo_pkg::PH_POWER;
			end
		endcase

		if (trans) begin
			core_d.latch[sel] = sampled;
			core_d.dirCw = edge_cw(sel, sampled, core_q.latch[~sel]);
			core_d.lastCh = sel;
			core_d.dirValid = 1'b1;
			core_d.spdPend = 1'b1;
			core_d.dlyCnt = 8'(DIR_DLY_CYC);
		end else if (core_q.spdPend) begin
			core_d.dlyCnt = core_q.dlyCnt - 8'h01;
			if (core_q.dlyCnt == 8'h01) begin
				core_d.spdPend = 1'b0;
				core_d.speed = core_q.latch[0] ^ core_q.latch[1];
			end
		end

		// Pin levels: released high through power-on, then by mode.
		if (core_d.phase == dclo_pkg::PH_POWER) begin
			core_d.pinLvl = 2'h3;
		end else if (SPEED_DIR_MODE) begin
			core_d.pinLvl[0] = core_d.speed;
			core_d.pinLvl[1] = core_d.dirValid ? dirLevelNext(core_d.dirCw) : 1'b1;
		end else begin
			core_d.pinLvl = core_d.latch;
		end

		// Register access.
		core_d.pslverr = 1'b0;
		if (setup) begin
			core_d.prdata = '0;
			if (apbReq.paddr == `DCLO_CTRL_OFS) begin
				core_d.prdata[`DCLO_CTRL_DIRINV_BIT] = core_q.dirInv;
			end else if (apbReq.paddr == `DCLO_STATUS_OFS) begin
				core_d.prdata[`DCLO_STAT_LATCH_LSB +: 2] = core_q.latch;
				core_d.prdata[`DCLO_STAT_POS_BIT] = (core_q.phase == dclo_pkg::PH_POS);
				core_d.prdata[`DCLO_STAT_RUN_BIT] = (core_q.phase == dclo_pkg::PH_RUN);
				core_d.prdata[`DCLO_STAT_DIRVALID_BIT] = core_q.dirValid;
				core_d.prdata[`DCLO_STAT_SPEED_BIT] = core_q.speed;
				core_d.prdata[`DCLO_STAT_PINS_LSB +: 2] = core_q.pinLvl;
			end else begin
				core_d.pslverr = 1'b1;
			end
		end else if (apbReq.psel && apbReq.penable) begin
			core_d.pslverr = core_q.pslverr;
		end
		if (wrAcc && (apbReq.paddr == `DCLO_CTRL_OFS) && apbReq.pstrb[0]) begin
			core_d.dirInv = apbReq.pwdata[`DCLO_CTRL_DIRINV_BIT];
		end

		// A software restart replays the whole power-on sequence.
		if (restart) begin
			core_d.phase = dclo_pkg::PH_POWER;
			core_d.porCnt = '0;
			core_d.lowCnt = '0;
			core_d.setLow = '0;
			core_d.spdPend = 1'b0;
			core_d.dirValid = 1'b0;
			core_d.pinLvl = 2'h3;
		end
	end

	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			core_q <= '0;
			core_q.phase <= dclo_pkg::PH_POWER;
			core_q.pinLvl <= 2'h3;
			core_q.dirInv <= 1'(`DCLO_CTRL_RESET >> `DCLO_CTRL_DIRINV_BIT);
		end else begin
			core_q <= core_d;
		end
	end

	// ****************************************
	// Outputs
	// ****************************************

	// Open drain: the enable goes low to pull the pin low.
	assign pinOut = 2'h0;
	assign pinOeN = core_q.pinLvl;
	assign apbRsp = '{prdata: core_q.prdata, pready: 1'b1, pslverr: core_q.pslverr && apbReq.psel && apbReq.penable};

	// ****************************************
	// Assertions
	// ****************************************

	localparam int DLY = DIR_DLY_CYC;

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence s_speed_hold;
		core_q.speed == $past(core_q.speed);
	endsequence

	sequence s_speed_flip;
		core_q.speed != $past(core_q.speed);
	endsequence

	property p_dir_before_speed;
		(trans && !restart && SPEED_DIR_MODE) |-> ##[DLY:DLY] s_speed_hold ##1 s_speed_flip;
	endproperty
	a_dir_before_speed: assert property (p_dir_before_speed) else $error("Speed edge not delayed after direction.");

	property p_dir_flip;
		(trans && !restart && core_q.dirValid && (sel == core_q.lastCh)) |=> (core_q.dirCw != $past(core_q.dirCw));
	endproperty
	a_dir_flip: assert property (p_dir_flip) else $error("Repeated channel edge did not flip direction.");

	property p_latch_at_slot_end;
		(active && $changed(core_q.latch) && !$past(restart) && !$past(porDone)) |-> $past(slotEnd);
	endproperty
	a_latch_at_slot_end: assert property (p_latch_at_slot_end) else $error("Latch changed away from a slot end.");

	property p_quad_direct;
		(!SPEED_DIR_MODE && active) |-> (pinOeN == core_q.latch);
	endproperty
	a_quad_direct: assert property (p_quad_direct) else $error("Quadrature pins do not follow the latches.");

	property p_high_at_power;
		(core_q.phase == dclo_pkg::PH_POWER) |-> (pinOeN == 2'h3);
	endproperty
	a_high_at_power: assert property (p_high_at_power) else $error("Output pulled low during power-on.");

	property p_pos_exit;
		(core_q.phase == dclo_pkg::PH_POS && trans && !restart) |=> (core_q.phase == dclo_pkg::PH_RUN);
	endproperty
	a_pos_exit: assert property (p_pos_exit) else $error("Setting mode not left on a transition.");

	property p_dir_high_init;
		(SPEED_DIR_MODE && active && !core_q.dirValid) |-> (pinOeN[1] == 1'b1);
	endproperty
	a_dir_high_init: assert property (p_dir_high_init) else $error("Direction not high before first transition.");

	property p_speed_xor;
		(SPEED_DIR_MODE && active && !core_q.spdPend) |-> (core_q.speed == (core_q.latch[0] ^ core_q.latch[1]));
	endproperty
	a_speed_xor: assert property (p_speed_xor) else $error("Speed is not the xor of the latches.");

	property p_band_default_high;
		(porDone && !restart && !core_q.setLow[0] && !core_q.setLow[1] && band[0]) |=> core_q.latch[0];
	endproperty
	a_band_default_high: assert property (p_band_default_high) else $error("Band channel did not wake high.");

endmodule : dclo_top
`default_nettype wire

// *** tb/dclo_host_model.sv ***
`timescale 1ns/100ps
`default_nettype none
// ****************************************
// Host side of the open-drain output pins.
// ****************************************
module dclo_host_model (
	input wire logic clk,
	input wire logic pulseGo,
	input wire logic [1:0] pulseMask,
	input wire logic [7:0] pulseLen,
	input wire logic [1:0] pinOut,
	input wire logic [1:0] pinOeN,
	output logic [1:0] pinIn,
	output int spdEdges
);
	logic [7:0] cnt = 8'h00;
	logic lastSpd = 1'b1;
	int edgeCnt = 0;
	assign spdEdges = edgeCnt;
	// The pins have pull-ups, so a wire is low whenever any party pulls it down.
	assign pinIn = (pinOeN | pinOut) & ~((cnt != 8'h00) ? pulseMask : 2'b00);
	always @(posedge clk) begin
		if (pulseGo && cnt == 8'h00) begin
			cnt <= pulseLen;
		end else if (cnt != 8'h00) begin
			cnt <= cnt - 8'h01;
		end
		lastSpd <= pinIn[0];
		if (pinIn[0] != lastSpd) begin
			edgeCnt <= edgeCnt + 1;
		end
	end
endmodule : dclo_host_model
`default_nettype wire

// *** tb/test_dclo_top.sv ***
`timescale 1ns/100ps
`default_nettype none
module test_dclo_top;
	localparam int PON = 200;
	localparam int SLOT = 20;
	localparam int DLY = 4;
	logic clk, rstn, pulseGo, err, hi, mA, mB, mDir, mInv, cw, ch, prevDir;
	dclo_pkg::dclo_apb_req_t req;
	dclo_pkg::dclo_apb_rsp_t rsp;
	dclo_pkg::dclo_field_t fld;
	logic [1:0] pinIn, pinOut, pinOeN, pd, pinInQ, pinOutQ, pinOeNQ;
	logic [31:0] rd;
	int spdEdges, failures, checked, seed, tDir, tSpd, n, e0;

	dclo_top #(.POWER_ON_CYC(PON), .SLOT_CYC(SLOT), .POS_MIN_CYC(10), .DIR_DLY_CYC(DLY)) i_dclo_top (
		.clk(clk), .rstn(rstn), .apbReq(req), .apbRsp(rsp), .field(fld),
		.pinIn(pinIn), .pinOut(pinOut), .pinOeN(pinOeN));
	dclo_host_model i_dclo_host_model (
		.clk(clk), .pulseGo(pulseGo), .pulseMask(2'b11), .pulseLen(8'h0F),
		.pinOut(pinOut), .pinOeN(pinOeN), .pinIn(pinIn), .spdEdges(spdEdges));
	// A quadrature build sees the same field; its host pulses channel A only.
	dclo_top #(.SPEED_DIR_MODE(1'b0), .POWER_ON_CYC(PON), .SLOT_CYC(SLOT), .POS_MIN_CYC(10), .DIR_DLY_CYC(DLY))
		i_dclo_top_quad (
		.clk(clk), .rstn(rstn), .apbReq('0), .apbRsp(), .field(fld),
		.pinIn(pinInQ), .pinOut(pinOutQ), .pinOeN(pinOeNQ));
	dclo_host_model i_dclo_host_model_quad (
		.clk(clk), .pulseGo(pulseGo), .pulseMask(2'b01), .pulseLen(8'h0F),
		.pinOut(pinOutQ), .pinOeN(pinOeNQ), .pinIn(pinInQ), .spdEdges());

	initial begin
		clk = 1'b0;
		forever #20 clk = ~clk;
	end

	// ****************************************
	// Comparison, verdict and bus cycles.
	// ****************************************
	task chk(input logic [31:0] got, input logic [31:0] exp);
		checked++;
		if (got !== exp) begin
			failures++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask : chk

	task give_verdict;
		$display("checked=%0d failures=%0d", checked, failures);
		if (failures == 0 && checked > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask : give_verdict

	task apb(input logic w, input logic [11:0] a, input logic [31:0] d, output logic [31:0] r, output logic e);
		int k;
		logic rdy;
		@(posedge clk);
		req.psel <= 1'b1;
		req.penable <= 1'b0;
		req.pwrite <= w;
		req.paddr <= a;
		req.pwdata <= d;
		req.pstrb <= 4'hF;
		@(posedge clk);
		req.penable <= 1'b1;
		k = 0;
		rdy = 1'b0;
		// The answer is read while it stands, before the edge that completes the access.
		while (rdy !== 1'b1 && k < 50) begin
			@(negedge clk);
			rdy = rsp.pready;
			r = rsp.prdata;
			e = rsp.pslverr;
			@(posedge clk);
			k++;
		end
		req.psel <= 1'b0;
		req.penable <= 1'b0;
		if (rdy !== 1'b1) begin
			failures++;
			give_verdict;
		end
	endtask : apb

	initial begin
		seed = 32'hAFA2;
		failures = 0;
		checked = 0;
		rstn = 1'b0;
		req = '0;
		fld = '0;
		fld.beyondRp = 2'b10;
		pulseGo = 1'b0;
		mInv = 1'b0;
		repeat (4) @(posedge clk);
		rstn <= 1'b1;
		// Both pins of the speed/direction build and pin A of the quadrature build are pulled low while the target stands still.
		pulseGo <= 1'b1;
		@(posedge clk);
		pulseGo <= 1'b0;
		hi = 1'b1;
		repeat (PON - 10) begin
			@(posedge clk);
			hi &= (pinOeN === 2'b11);
		end
		chk({31'h0, hi}, 32'h1);
		repeat (30) @(posedge clk);
		chk({30'h0, pinOeN}, 32'h2);
		chk({30'h0, pinOeNQ}, 32'h2);
		apb(1'b0, 12'h004, 32'h0, rd, err);
		chk({28'h0, rd[7:6], rd[3:2]}, 32'h9);
		apb(1'b0, 12'h008, 32'h0, rd, err);
		chk({err, rd[30:0]}, 32'h80000000);
		mA = 1'b1;
		mB = 1'b1;
		mDir = 1'b1;
		e0 = spdEdges;
		for (int s = 0; s < 24; s++) begin
			if (s == 12) begin
				apb(1'b1, 12'h000, 32'h2, rd, err);
				apb(1'b0, 12'h000, 32'h0, rd, err);
				chk(rd, 32'h2);
				mInv = 1'b1;
				mDir = ~mDir;
				repeat (3) @(posedge clk);
				chk({31'h0, pinOeN[1]}, {31'h0, mDir});
			end
			ch = ($random(seed) & 1) != 0;
			prevDir = mDir;
			if (ch == 1'b0) begin
				mA = ~mA;
				cw = (mA != mB);
			end else begin
				mB = ~mB;
				cw = (mB == mA);
			end
			mDir = cw ^ mInv;
			pd = pinOeN;
			fld.beyondOp[ch] <= ch ? ~mB : ~mA;
			fld.beyondRp[ch] <= ch ? mB : mA;
			tDir = -1;
			tSpd = -1;
			n = 0;
			while (tSpd < 0 && n < 2 * SLOT + DLY + 20) begin
				@(posedge clk);
				n++;
				if (tDir < 0 && pinOeN[1] !== pd[1]) tDir = n;
				if (pinOeN[0] !== pd[0]) tSpd = n;
			end
			if (tSpd < 0) begin
				failures++;
				give_verdict;
			end
			chk({30'h0, pinOeN}, {30'h0, mDir, mA ^ mB});
			chk({30'h0, pinOeNQ}, {30'h0, mB, mA});
			if (mDir != prevDir) chk(tSpd - tDir, DLY);
			repeat ($random(seed) & 31) @(posedge clk);
		end
		chk(spdEdges - e0, 24);
		apb(1'b0, 12'h004, 32'h0, rd, err);
		chk({30'h0, rd[3:2]}, 32'h2);
		// A software restart replays power-on without a setting pulse.
		apb(1'b1, 12'h000, 32'h3, rd, err);
		hi = 1'b1;
		repeat (PON - 10) begin
			@(posedge clk);
			hi &= (pinOeN === 2'b11);
		end
		chk({31'h0, hi}, 32'h1);
		repeat (30) @(posedge clk);
		apb(1'b0, 12'h004, 32'h0, rd, err);
		chk({28'h0, rd[7], rd[4:2]}, 32'h9);
		give_verdict;
	end
endmodule : test_dclo_top
`default_nettype wire
